//--- bcd_counter.sv
// one loadable bcd counter with wrap from a top value to a bottom value
// assumes width of at least five bits so there is a tens digit
`timescale 1ns/1ps
module bcd_counter #(
    parameter int                 WIDTH   = 8,
    parameter logic [WIDTH-1:0]   MIN_VAL = '0,
    parameter logic [WIDTH-1:0]   MAX_VAL = '1,
    parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    input  wire logic             inc,
    output logic      [WIDTH-1:0] value,
    output logic                  carry
);
    localparam int HW = WIDTH - 4;

    logic [WIDTH-1:0] value_next;
    logic [HW-1:0]    tens_next;
    logic             at_top;

    // values at or above the top, including out of range ones written by the host, fall back to the bottom
    assign at_top    = (value >= MAX_VAL);
    assign tens_next = value[WIDTH-1:4] + 1'b1;
    assign carry     = inc && !load && at_top;

    // decimal step of the two digit value
    always_comb begin
        value_next = value;
        if (at_top) begin
            value_next = MIN_VAL;
        end else if (value[3:0] >= cal_pkg::BCD_NINE) begin
            value_next = {tens_next, cal_pkg::BCD_ZERO};
        end else begin
            value_next = {value[WIDTH-1:4], value[3:0] + 4'h1};
        end
    end

    // host load beats the count so a correction is never undone
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            value <= RST_VAL;
        end else if (load) begin
            value <= load_val;
        end else if (inc) begin
            value <= value_next;
        end
    end
endmodule

//--- cal_pkg.sv
// constants shared by the calendar register block and its digit counters
// assumes a single 200 MHz clock domain and a synchronous active high reset
package cal_pkg;
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 3;
    // register indices on the device register port
    localparam logic [2:0]  ADDR_DATE     = 3'h3;
    localparam logic [2:0]  ADDR_PERIOD   = 3'h4;
    localparam logic [2:0]  ADDR_YEAR     = 3'h5;
    localparam logic [2:0]  ADDR_WEEKDAY  = 3'h6;
    // field widths inside each byte
    localparam int          DATE_W        = 6;
    localparam int          PERIOD_W      = 5;
    localparam int          YEAR_W        = 8;
    localparam int          WEEKDAY_W     = 3;
    // reset values
    localparam logic [5:0]  DATE_RST      = 6'h01;
    localparam logic [4:0]  PERIOD_RST    = 5'h01;
    localparam logic [7:0]  YEAR_RST      = 8'h00;
    localparam logic [2:0]  WEEKDAY_RST   = 3'h0;
    // counting ranges in bcd
    localparam logic [5:0]  DATE_MIN      = 6'h01;
    localparam logic [5:0]  DATE_MAX      = 6'h31;
    localparam logic [4:0]  PERIOD_MIN    = 5'h01;
    localparam logic [4:0]  PERIOD_MAX    = 5'h12;
    localparam logic [7:0]  YEAR_MIN      = 8'h00;
    localparam logic [7:0]  YEAR_MAX      = 8'h99;
    localparam logic [2:0]  WEEKDAY_MIN   = 3'h0;
    localparam logic [2:0]  WEEKDAY_MAX   = 3'h6;
    localparam logic [2:0]  WEEKDAY_ONE   = 3'h1;
    // bcd digit helpers
    localparam logic [3:0]  BCD_NINE      = 4'h9;
    localparam logic [3:0]  BCD_ZERO      = 4'h0;
    localparam logic [7:0]  READ_ZERO     = 8'h00;
endpackage

//--- host_model.sv
// host side model: register port master plus the day carry source
// assumes the block samples strobes on the rising edge; we drive on falling
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk,
    output logic            day_carry,
    output logic      [2:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    // idle state; released lines show the inverse so stale values never match
    initial begin
        day_carry = 1'b0;
        reg_addr  = 3'h0;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end

    // one byte write, optionally with a day carry in the same cycle
    task automatic write(input logic [2:0] addr, input logic [7:0] data, input logic carry);
        @(negedge clk);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        day_carry = carry;
        @(negedge clk);
        reg_wr    = 1'b0;
        day_carry = 1'b0;
        reg_addr  = ~addr;
        reg_wdata = ~data;
    endtask

    // one byte read; bounded wait for the valid pulse
    task automatic read(input logic [2:0] addr, output logic [7:0] data, output logic ok);
        int n;
        @(negedge clk);
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~addr;
        ok       = 1'b0;
        data     = 8'h00;
        for (n = 0; n < 4 && !ok; n++) begin
            if (reg_rvalid === 1'b1) begin
                data = reg_rdata;
                ok   = 1'b1;
            end else begin
                @(negedge clk);
            end
        end
    endtask

    // back to back day carries
    task automatic step(input int count);
        @(negedge clk);
        day_carry = 1'b1;
        repeat (count) @(negedge clk);
        day_carry = 1'b0;
    endtask

    // calendar fix: month first, date last so the carry lands with the date write
    task automatic correct(input logic [7:0] month, input logic [7:0] date, input logic carry);
        write(cal_pkg::ADDR_PERIOD, month, 1'b0);
        write(cal_pkg::ADDR_DATE, date, carry);
    endtask
endmodule

//--- rtc_calendar_registers.sv
// calendar registers: date, month, year and weekday, advanced by the day carry
// assumes reg port strobes are synchronous one-cycle pulses from the serial front end
`timescale 1ns/1ps
// What this block does
// - keep the day of month as two bcd digits, 1 to 31
// - date in bits 5..0, bits 7..6 read zero, resets to one
// - keep the month as two bcd digits, 1 January to 12 December
// - month in bits 4..0, bits 7..5 read zero, zero invalid, resets to one
// - keep the year as full byte bcd 0 to 99, resets to zero
// - weekday three bit code 000 first day, upper bits zero, resets zero
module rtc_calendar_registers (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       day_carry,
    input  wire logic [2:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    output logic      [5:0] calendar_date_field,
    output logic      [4:0] cal_period_index,
    output logic      [7:0] calendar_year_field,
    output logic      [2:0] weekday_index
);
    logic       wr_date;
    logic       wr_period;
    logic       wr_year;
    logic       wr_weekday;
    logic       date_carry;
    logic       period_carry;
    logic [2:0] weekday_reg;
    logic [2:0] weekday_next;
    logic [7:0] rdata_reg;
    logic       rvalid_reg;
    logic [7:0] rdata_next;

    // write decode per register
    assign wr_date    = reg_wr && (reg_addr == cal_pkg::ADDR_DATE);
    assign wr_period  = reg_wr && (reg_addr == cal_pkg::ADDR_PERIOD);
    assign wr_year    = reg_wr && (reg_addr == cal_pkg::ADDR_YEAR);
    assign wr_weekday = reg_wr && (reg_addr == cal_pkg::ADDR_WEEKDAY);

    // date counter, carries into month at the 31st
    bcd_counter #(
        .WIDTH   (cal_pkg::DATE_W),
        .MIN_VAL (cal_pkg::DATE_MIN),
        .MAX_VAL (cal_pkg::DATE_MAX),
        .RST_VAL (cal_pkg::DATE_RST)
    ) u_date (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .load     (wr_date),
        .load_val (reg_wdata[cal_pkg::DATE_W-1:0]),
        .inc      (day_carry),
        .value    (calendar_date_field),
        .carry    (date_carry)
    );

    // month counter; a written zero is left alone until the next step
    bcd_counter #(
        .WIDTH   (cal_pkg::PERIOD_W),
        .MIN_VAL (cal_pkg::PERIOD_MIN),
        .MAX_VAL (cal_pkg::PERIOD_MAX),
        .RST_VAL (cal_pkg::PERIOD_RST)
    ) u_period (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .load     (wr_period),
        .load_val (reg_wdata[cal_pkg::PERIOD_W-1:0]),
        .inc      (date_carry),
        .value    (cal_period_index),
        .carry    (period_carry)
    );

    // year counter, no century beyond 99
    bcd_counter #(
        .WIDTH   (cal_pkg::YEAR_W),
        .MIN_VAL (cal_pkg::YEAR_MIN),
        .MAX_VAL (cal_pkg::YEAR_MAX),
        .RST_VAL (cal_pkg::YEAR_RST)
    ) u_year (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .load     (wr_year),
        .load_val (reg_wdata),
        .inc      (period_carry),
        .value    (calendar_year_field),
        .carry    ()
    );

    // weekday is plain binary, codes 7 and up recover to the first day
    always_comb begin
        if (weekday_reg >= cal_pkg::WEEKDAY_MAX) begin
            weekday_next = cal_pkg::WEEKDAY_MIN;
        end else begin
            weekday_next = weekday_reg + cal_pkg::WEEKDAY_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            weekday_reg <= cal_pkg::WEEKDAY_RST;
        end else if (wr_weekday) begin
            weekday_reg <= reg_wdata[cal_pkg::WEEKDAY_W-1:0];
        end else if (day_carry) begin
            weekday_reg <= weekday_next;
        end
    end

    assign weekday_index = weekday_reg;

    // read mux, unused bits and unmapped indices give zero
    always_comb begin
        rdata_next = cal_pkg::READ_ZERO;
        case (reg_addr)
            cal_pkg::ADDR_DATE: begin
                rdata_next[cal_pkg::DATE_W-1:0] = calendar_date_field;
            end
            cal_pkg::ADDR_PERIOD: begin
                rdata_next[cal_pkg::PERIOD_W-1:0] = cal_period_index;
            end
            cal_pkg::ADDR_YEAR: begin
                rdata_next = calendar_year_field;
            end
            cal_pkg::ADDR_WEEKDAY: begin
                rdata_next[cal_pkg::WEEKDAY_W-1:0] = weekday_reg;
            end
            default: begin
                rdata_next = cal_pkg::READ_ZERO;
            end
        endcase
    end

    // registered read data, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg  <= cal_pkg::READ_ZERO;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd;
            if (reg_rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign reg_rdata  = rdata_reg;
    assign reg_rvalid = rvalid_reg;

    // checks
    sequence s_no_wr;
        !reg_wr;
    endsequence

    // a carry on the last day of the last month with no host write alongside
    sequence s_year_end;
        s_no_wr ##0 (day_carry && calendar_date_field == cal_pkg::DATE_MAX
            && cal_period_index == cal_pkg::PERIOD_MAX);
    endsequence

    property p_reset_vals;
        @(posedge clk) sys_rst |=> calendar_date_field == cal_pkg::DATE_RST
            && cal_period_index == cal_pkg::PERIOD_RST
            && calendar_year_field == cal_pkg::YEAR_RST && weekday_index == cal_pkg::WEEKDAY_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

    property p_date_wrap;
        @(posedge clk) disable iff (sys_rst)
        day_carry && !reg_wr && calendar_date_field == cal_pkg::DATE_MAX
            |=> calendar_date_field == cal_pkg::DATE_MIN && $changed(cal_period_index);
    endproperty
    a_date_wrap: assert property (p_date_wrap) else $error("date wrap wrong");

    property p_date_digit;
        @(posedge clk) disable iff (sys_rst)
        day_carry && !reg_wr && calendar_date_field == 6'h09 |=> calendar_date_field == 6'h10;
    endproperty
    a_date_digit: assert property (p_date_digit) else $error("date bcd step wrong");

    property p_month_wrap;
        @(posedge clk) disable iff (sys_rst)
        s_year_end |=> cal_period_index == cal_pkg::PERIOD_MIN
            && calendar_year_field != $past(calendar_year_field);
    endproperty
    a_month_wrap: assert property (p_month_wrap) else $error("month wrap wrong");

    property p_year_wrap;
        @(posedge clk) disable iff (sys_rst)
        s_year_end ##0 (calendar_year_field == cal_pkg::YEAR_MAX)
            |=> calendar_year_field == cal_pkg::YEAR_MIN;
    endproperty
    a_year_wrap: assert property (p_year_wrap) else $error("year wrap wrong");

    property p_weekday_wrap;
        @(posedge clk) disable iff (sys_rst)
        day_carry && !reg_wr && weekday_index == cal_pkg::WEEKDAY_MAX
            |=> weekday_index == cal_pkg::WEEKDAY_MIN;
    endproperty
    a_weekday_wrap: assert property (p_weekday_wrap) else $error("weekday wrap wrong");

    property p_read_upper;
        @(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr == cal_pkg::ADDR_PERIOD
            |=> reg_rvalid && reg_rdata[7:5] == 3'h0 && reg_rdata[4:0] == $past(cal_period_index);
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("month readback wrong");

    property p_date_load;
        @(posedge clk) disable iff (sys_rst)
        wr_date |=> calendar_date_field == $past(reg_wdata[5:0]);
    endproperty
    a_date_load: assert property (p_date_load) else $error("date write lost");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
        !day_carry && !reg_wr |=> $stable(calendar_date_field) && $stable(cal_period_index)
            && $stable(calendar_year_field) && $stable(weekday_index);
    endproperty
    a_hold: assert property (p_hold) else $error("calendar moved without cause");
endmodule

//--- tb_top.sv
// self-checking bench for the calendar registers through the host model
// assumes host_model and rtc_calendar_registers compiled alongside cal_pkg
`timescale 1ns/1ps
module tb_top;
    logic       clk;
    logic       sys_rst;
    logic       day_carry;
    logic [2:0] reg_addr;
    logic       reg_wr;
    logic [7:0] reg_wdata;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic [5:0] date_f;
    logic [4:0] period_f;
    logic [7:0] year_f;
    logic [2:0] wday_f;
    int         n_errors;
    int         samples_checked;
    // carry table rows packed as date, month, year, weekday
    logic [31:0] pre  [6] = '{32'h31129906, 32'h09051900, 32'h31091901,
                              32'h31121902, 32'h31005005, 32'h29022403};
    logic [31:0] post [6] = '{32'h01010000, 32'h10051901, 32'h01101902,
                              32'h01012003, 32'h01015006, 32'h30022404};

    always #2.5 clk = ~clk;

    host_model i_host_model (.clk(clk), .day_carry(day_carry), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    rtc_calendar_registers i_rtc_calendar_registers (.clk(clk), .sys_rst(sys_rst),
        .day_carry(day_carry), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .calendar_date_field(date_f),
        .cal_period_index(period_f), .calendar_year_field(year_f),
        .weekday_index(wday_f));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // read through the host and compare; a lost valid pulse ends the run
    task automatic rd_chk(input logic [2:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        i_host_model.read(addr, d, ok);
        if (ok !== 1'b1) begin
            n_errors++;
            report_and_stop();
        end else begin
            check(d, exp);
        end
    endtask

    // packed date, month, year, weekday against the field outputs
    task automatic fields_chk(input logic [31:0] exp);
        check({2'h0, date_f}, exp[31:24]);
        check({3'h0, period_f}, exp[23:16]);
        check(year_f, exp[15:8]);
        check({5'h0, wday_f}, exp[7:0]);
    endtask

    task automatic load_all(input logic [31:0] v);
        i_host_model.write(cal_pkg::ADDR_DATE, v[31:24], 1'b0);
        i_host_model.write(cal_pkg::ADDR_PERIOD, v[23:16], 1'b0);
        i_host_model.write(cal_pkg::ADDR_YEAR, v[15:8], 1'b0);
        i_host_model.write(cal_pkg::ADDR_WEEKDAY, v[7:0], 1'b0);
    endtask

    initial begin
        clk             = 1'b0;
        sys_rst         = 1'b1;
        n_errors        = 0;
        samples_checked = 0;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        // reset values seen through reads and on the field outputs
        rd_chk(cal_pkg::ADDR_DATE, 8'h01);
        rd_chk(cal_pkg::ADDR_PERIOD, 8'h01);
        rd_chk(cal_pkg::ADDR_YEAR, 8'h00);
        rd_chk(cal_pkg::ADDR_WEEKDAY, 8'h00);
        fields_chk(32'h01010000);
        $display("test reset values done");
        // unused high bits dropped, unmapped index ignored and reads zero
        load_all(32'hFFF299FE);
        i_host_model.write(3'h7, 8'h55, 1'b0);
        rd_chk(cal_pkg::ADDR_DATE, 8'h3F);
        rd_chk(cal_pkg::ADDR_PERIOD, 8'h12);
        rd_chk(cal_pkg::ADDR_YEAR, 8'h99);
        rd_chk(cal_pkg::ADDR_WEEKDAY, 8'h06);
        rd_chk(3'h7, 8'h00);
        $display("test field masks done");
        // day carry table: digit carries, wraps and the invalid month code
        for (int i = 0; i < 6; i++) begin
            load_all(pre[i]);
            i_host_model.step(1);
            fields_chk(post[i]);
        end
        rd_chk(cal_pkg::ADDR_DATE, 8'h30);
        $display("test day carry done");
        // host fix lands with a carry: the date write wins over the step while the weekday still advances
        i_host_model.correct(8'h03, 8'h01, 1'b1);
        fields_chk(32'h01032405);
        i_host_model.step(3);
        fields_chk(32'h04032401);
        rd_chk(cal_pkg::ADDR_PERIOD, 8'h03);
        $display("test host correction done");
        // reset in mid-run puts every field back and clears the read port
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        check(reg_rdata, 8'h00);
        check({7'h0, reg_rvalid}, 8'h00);
        fields_chk(32'h01010000);
        rd_chk(cal_pkg::ADDR_YEAR, 8'h00);
        rd_chk(cal_pkg::ADDR_DATE, 8'h01);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule
